// ===== sram_port_pkg.sv
package sram_port_pkg;

   localparam int ADDR_W = 22;
   localparam int INDEX_W = 21;
   localparam int DATA_W = 36;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int WORDS = 2097152;
   localparam int BUS_W = 32;

   // Register map on the AHB-Lite slave, byte addresses.
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [3:0] CAPTURE_OFFSET = 4'h8;

   // Control register fields.
   localparam int CTRL_CAPTURE_BIT = 0;
   localparam int CTRL_ORG18_BIT = 1;
   localparam logic CTRL_CAPTURE_RESET = 1'b0;
   localparam logic CTRL_ORG18_RESET = 1'b0;

   // Status register fields.
   localparam int STATUS_ASLEEP_BIT = 0;
   localparam int STATUS_AVAIL_BIT = 1;
   localparam int STATUS_DROPPED_BIT = 2;
   localparam int STATUS_BURST_ORDER_BIT = 3;

   localparam int CAPTURE_DEPTH = 8;

   // Sleep entry and wake-up, in clock cycles.
   localparam int SLEEP_ENTRY_CYCLES = 2;
   localparam int SLEEP_WAKE_CYCLES = 2;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;

   typedef enum logic [2:0] {
      OP_IDLE = 3'b001,
      OP_READ = 3'b010,
      OP_WRITE = 3'b100
   } op_t;

   typedef enum logic [1:0] {
      PWR_RUN = 2'b01,
      PWR_SLEEP = 2'b10
   } power_t;

endpackage

// ===== pipelined_sync_sram_port.sv
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// How it works
// - Array holds 2M words of 36 bits, or 4M of 18 bits when org18 set.
// - Address, data and controls sample on mclk; output enable and burst order first pass through two-flop mclk synchronisers.
// - Sleep request is asynchronous and is synchronised before use.
// - A write starts on a clock edge; the array write is timed internally.
// - Read data lands in an output register, driven one edge later.
// - Output enable turns the data pins off regardless of commands; the pins drive only in the cycle after read data was in the output register.
// - The two low address bits seed the burst counter on a load.
// - Three chip selects must all be active for a load to start a cycle.
// - Inactive clock enable suspends operation; the edge leaves the pipeline registers unchanged.
// - Interleaved and linear burst orders are both supported.
// - Write data arrives two edges after its address and write select.
// - Clock enable high freezes the pipeline registers; synchronisers, power state, pin enable and bus registers keep running.
// - Burst-order select low means linear, high means interleaved.
// - Sleep entered within 2 cycles of request, exit 2 cycles after release.

module fifo_buffer #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PTR_W = $clog2(DEPTH);

   typedef struct packed {
      logic [PTR_W-1:0] wrPtr;
      logic [PTR_W-1:0] rdPtr;
      logic [PTR_W:0] level;
   } fifo_state_t;

   fifo_state_t fifo_reg;
   fifo_state_t fifo_next;
   logic [WIDTH-1:0] slots [0:DEPTH-1];
   logic push;
   logic pop;

   assign inReady = fifo_reg.level != (PTR_W+1)'(DEPTH);
   assign outValid = fifo_reg.level != '0;
   assign outData = slots[fifo_reg.rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      fifo_next = fifo_reg;
      if (push) begin
         fifo_next.wrPtr = fifo_reg.wrPtr + 1'b1;
      end
      if (pop) begin
         fifo_next.rdPtr = fifo_reg.rdPtr + 1'b1;
      end
      if (push && !pop) begin
         fifo_next.level = fifo_reg.level + 1'b1;
      end else if (pop && !push) begin
         fifo_next.level = fifo_reg.level - 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fifo_reg <= '0;
      end else begin
         fifo_reg <= fifo_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         slots[fifo_reg.wrPtr] <= inData;
      end
   end
endmodule

module pipelined_sync_sram_port (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [sram_port_pkg::ADDR_W-1:0] address,
   input wire logic advanceOrLoad,
   input wire logic writeSelect_n,
   input wire logic clockEnable_n,
   input wire logic chipSelectFirst_n,
   input wire logic chipSelectSecond,
   input wire logic chipSelectThird_n,
   input wire logic [sram_port_pkg::LANES-1:0] byteWrite_n,
   input wire logic outputEnable_n,
   input wire logic sleepRequest,
   input wire logic burstOrderSelect,
   input wire logic [sram_port_pkg::DATA_W-1:0] dataIn,
   output logic [sram_port_pkg::DATA_W-1:0] dataOut,
   output logic dataOe_n,
   output logic captureReady,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   import sram_port_pkg::*;

   typedef struct packed {
      logic sleepS1;
      logic sleepS2;
      logic oeS1;
      logic oeS2;
      logic orderS1;
      logic orderS2;
      power_t pwr;
      op_t aOp;
      logic [ADDR_W-1:0] aAddr;
      logic [LANES-1:0] aBw;
      op_t burstOp;
      logic [1:0] burstSeed;
      logic [1:0] burstStep;
      op_t bOp;
      logic [ADDR_W-1:0] bAddr;
      logic [LANES-1:0] bBw;
      logic [DATA_W-1:0] readWord;
      logic [DATA_W-1:0] outWord;
      logic outValid;
      logic dataOe_n;
      logic busWrite;
      logic [3:0] busAddr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic ctrlCapture;
      logic ctrlOrg18;
      logic dropped;
      logic captureReady;
   } port_state_t;

   port_state_t port_reg;
   port_state_t port_next;
   logic advance;
   logic selected;
   logic [LANES-1:0] laneWrite;
   logic [DATA_W-1:0] arrayWord;
   logic [DATA_W-1:0] writeWord;
   logic pushValid;
   logic pushReady;
   logic popReady;
   logic popValid;
   logic [BUS_W-1:0] popData;

   // Maps a device address to an array row for either organisation.
   function automatic logic [INDEX_W-1:0] wordIndex(input logic [ADDR_W-1:0] a, input logic org18);
      wordIndex = org18 ? a[ADDR_W-1:1] : a[INDEX_W-1:0];
   endfunction

   // Next burst address bits from the seed and step.
   function automatic logic [1:0] burstBits(input logic [1:0] seed, input logic [1:0] step,
                                            input logic interleaved);
      burstBits = interleaved ? (seed ^ step) : (seed + step);
   endfunction

   // Nine-bit lanes written by the byte-write inputs; an x18 word uses half a row.
   always_comb begin
      laneWrite = '0;
      if (port_reg.ctrlOrg18) begin
         if (port_reg.bAddr[0]) begin
            laneWrite[3:2] = ~port_reg.bBw[1:0];
         end else begin
            laneWrite[1:0] = ~port_reg.bBw[1:0];
         end
      end else begin
         laneWrite = ~port_reg.bBw;
      end
      writeWord = port_reg.ctrlOrg18 ? {dataIn[17:0], dataIn[17:0]} : dataIn;
   end

   // The second sleep flop gates the pipeline directly, so wake-up costs only the synchroniser.
   assign advance = !clockEnable_n && !port_reg.sleepS2;
   assign selected = !chipSelectFirst_n && chipSelectSecond && !chipSelectThird_n;
   assign pushValid = advance && port_reg.bOp == OP_READ && port_reg.ctrlCapture;

   fifo_buffer #(
      .WIDTH(BUS_W),
      .DEPTH(CAPTURE_DEPTH)
   ) capture_fifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .inValid(pushValid),
      .inReady(pushReady),
      .inData(port_reg.readWord[BUS_W-1:0]),
      .outValid(popValid),
      .outReady(popReady),
      .outData(popData)
   );

   assign popReady = hsel && hready && !hwrite && haddr[3:0] == CAPTURE_OFFSET &&
                     (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

   always_comb begin
      port_next = port_reg;
      port_next.sleepS1 = sleepRequest;
      port_next.sleepS2 = port_reg.sleepS1;
      port_next.oeS1 = outputEnable_n;
      port_next.oeS2 = port_reg.oeS1;
      port_next.orderS1 = burstOrderSelect;
      port_next.orderS2 = port_reg.orderS1;
      case (port_reg.pwr)
         PWR_RUN: begin
            if (port_reg.sleepS2) begin
               port_next.pwr = PWR_SLEEP;
            end
         end
         PWR_SLEEP: begin
            if (!port_reg.sleepS2) begin
               port_next.pwr = PWR_RUN;
            end
         end
         default: begin
            port_next.pwr = PWR_RUN;
         end
      endcase
      if (advance) begin
         if (!advanceOrLoad) begin
            port_next.aAddr = address;
            port_next.aBw = byteWrite_n;
            port_next.burstSeed = address[1:0];
            port_next.burstStep = 2'h0;
            if (!selected) begin
               port_next.aOp = OP_IDLE;
            end else if (!writeSelect_n) begin
               port_next.aOp = OP_WRITE;
            end else begin
               port_next.aOp = OP_READ;
            end
            port_next.burstOp = port_next.aOp;
         end else begin
            port_next.burstStep = port_reg.burstStep + 2'h1;
            port_next.aAddr[1:0] = burstBits(port_reg.burstSeed, port_next.burstStep,
                                             port_reg.orderS2);
            port_next.aBw = byteWrite_n;
            port_next.aOp = port_reg.burstOp;
         end
         port_next.bOp = port_reg.aOp;
         port_next.bAddr = port_reg.aAddr;
         port_next.bBw = port_reg.aBw;
         port_next.readWord = arrayWord;
         if (port_reg.ctrlOrg18) begin
            port_next.readWord = {18'h00000, port_reg.aAddr[0] ? arrayWord[35:18] : arrayWord[17:0]};
         end
         port_next.outWord = port_reg.readWord;
         port_next.outValid = port_reg.bOp == OP_READ;
      end
      port_next.dataOe_n = !(port_reg.outValid && !port_reg.oeS2 && port_reg.pwr == PWR_RUN);
      port_next.captureReady = pushReady;
      if (pushValid && !pushReady) begin
         port_next.dropped = 1'b1;
      end
      port_next.hreadyout = 1'b1;
      if (port_reg.busWrite) begin
         if (port_reg.busAddr == CTRL_OFFSET) begin
            port_next.ctrlCapture = hwdata[CTRL_CAPTURE_BIT];
            port_next.ctrlOrg18 = hwdata[CTRL_ORG18_BIT];
         end
         if (port_reg.busAddr == STATUS_OFFSET && hwdata[STATUS_DROPPED_BIT] &&
             !(pushValid && !pushReady)) begin
            port_next.dropped = 1'b0;
         end
      end
      port_next.busWrite = 1'b0;
      if (hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)) begin
         port_next.busWrite = hwrite;
         port_next.busAddr = haddr[3:0];
         port_next.hrdata = 32'h00000000;
         if (!hwrite) begin
            case (haddr[3:0])
               CTRL_OFFSET: begin
                  port_next.hrdata[CTRL_CAPTURE_BIT] = port_reg.ctrlCapture;
                  port_next.hrdata[CTRL_ORG18_BIT] = port_reg.ctrlOrg18;
               end
               STATUS_OFFSET: begin
                  port_next.hrdata[STATUS_ASLEEP_BIT] = port_reg.pwr == PWR_SLEEP;
                  port_next.hrdata[STATUS_AVAIL_BIT] = popValid;
                  port_next.hrdata[STATUS_DROPPED_BIT] = port_reg.dropped;
                  port_next.hrdata[STATUS_BURST_ORDER_BIT] = port_reg.orderS2;
               end
               CAPTURE_OFFSET: begin
                  port_next.hrdata = popValid ? popData : 32'h00000000;
               end
               default: begin
                  port_next.hrdata = 32'h00000000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         port_reg <= '0;
         port_reg.pwr <= PWR_RUN;
         port_reg.aOp <= OP_IDLE;
         port_reg.burstOp <= OP_IDLE;
         port_reg.bOp <= OP_IDLE;
         port_reg.dataOe_n <= 1'b1;
         port_reg.hreadyout <= 1'b1;
         port_reg.ctrlCapture <= CTRL_CAPTURE_RESET;
         port_reg.ctrlOrg18 <= CTRL_ORG18_RESET;
      end else begin
         port_reg <= port_next;
      end
   end

   // Late write: the data pins are sampled two edges after the write was loaded.
   genvar lane;
   generate
      for (lane = 0; lane < LANES; lane++) begin : g_lane
         // Each lane keeps its own array, so every array has exactly one writing process.
         logic [LANE_W-1:0] laneMem [0:WORDS-1];
         assign arrayWord[lane*LANE_W +: LANE_W] = laneMem[wordIndex(port_reg.aAddr, port_reg.ctrlOrg18)];
         always_ff @(posedge mclk) begin
            if (advance && port_reg.bOp == OP_WRITE && laneWrite[lane]) begin
               laneMem[wordIndex(port_reg.bAddr, port_reg.ctrlOrg18)] <=
                  writeWord[lane*LANE_W +: LANE_W];
            end
         end
      end
   endgenerate

   assign dataOut = port_reg.outWord;
   assign dataOe_n = port_reg.dataOe_n;
   assign captureReady = port_reg.captureReady;
   assign hreadyout = port_reg.hreadyout;
   assign hresp = 1'b0;
   assign hrdata = port_reg.hrdata;
endmodule

// ===== sram_port_properties.sv
`timescale 1ns/100ps
module sram_port_properties (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic advanceOrLoad,
   input wire logic writeSelect_n,
   input wire logic clockEnable_n,
   input wire logic chipSelectFirst_n,
   input wire logic chipSelectSecond,
   input wire logic chipSelectThird_n,
   input wire logic outputEnable_n,
   input wire logic sleepRequest,
   input wire logic [sram_port_pkg::DATA_W-1:0] dataOut,
   input wire logic dataOe_n,
   input wire logic captureReady,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata
);
   import sram_port_pkg::*;
   logic [2:0] quietCnt;
   logic rdLoad;
   logic good;
   assign rdLoad = !advanceOrLoad && writeSelect_n && !chipSelectFirst_n && chipSelectSecond && !chipSelectThird_n;
   assign good = !clockEnable_n && !sleepRequest && !outputEnable_n;
   // Counts awake cycles with output enable on, so the synchronisers have settled.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         quietCnt <= 3'h0;
      end else if (sleepRequest || outputEnable_n) begin
         quietCnt <= 3'h0;
      end else if (quietCnt != 3'h7) begin
         quietCnt <= quietCnt + 3'h1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   AST_READ_DRIVES: assert property ((rdLoad && good && quietCnt > 3'h3) ##1 good [*3] |=> !dataOe_n)
      else $error("read slot left the data pins undriven");
   AST_OE_OFF: assert property (outputEnable_n [*5] |-> dataOe_n)
      else $error("data pins driven with output enable off");
   AST_SLEEP_OFF: assert property (sleepRequest [*5] |-> dataOe_n)
      else $error("data pins driven while asleep");
   AST_SLEEP_HOLD: assert property (sleepRequest [*5] |=> $stable(dataOut))
      else $error("read data changed while asleep");
   AST_CKE_HOLD: assert property ($past(clockEnable_n) |-> $stable(dataOut))
      else $error("read data changed on an ignored edge");
   AST_AHB_OKAY: assert property (hreadyout && !hresp)
      else $error("bus slave stalled or answered with an error");
   AST_CAPTURE_UP: assert property ($rose(rst_b) |=> captureReady)
      else $error("capture buffer not ready after reset");
   AST_HRDATA_HOLD: assert property (!$past(hsel) || !$past(hready) || !$past(htrans[1]) |-> $stable(hrdata))
      else $error("read data changed without a bus transfer");
endmodule

// ===== sram_controller_model.sv
`timescale 1ns/100ps
module sram_controller_model (
   input wire logic mclk,
   output logic [sram_port_pkg::ADDR_W-1:0] address,
   output logic advanceOrLoad,
   output logic writeSelect_n,
   output logic chipSelectFirst_n,
   output logic chipSelectSecond,
   output logic chipSelectThird_n,
   output logic [sram_port_pkg::LANES-1:0] byteWrite_n,
   output logic [sram_port_pkg::DATA_W-1:0] dataIn
);
   import sram_port_pkg::*;
   logic [DATA_W-1:0] pipeData [2];
   logic [1:0] pipeWr;
   initial begin
      address = '0;
      advanceOrLoad = 1'b0;
      writeSelect_n = 1'b1;
      {chipSelectFirst_n, chipSelectSecond, chipSelectThird_n} = 3'h5;
      byteWrite_n = 4'hF;
      dataIn = '0;
      pipeWr = 2'h0;
      pipeData = '{default: '0};
   end
   // One command per edge, any mix, no idle turnaround; data lines toggle when no write is due.
   task automatic cycle(input logic wr, input logic ld, input logic [2:0] sel,
                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      address <= a;
      advanceOrLoad <= !ld;
      writeSelect_n <= !wr;
      chipSelectFirst_n <= !sel[0];
      chipSelectSecond <= sel[1];
      chipSelectThird_n <= !sel[2];
      byteWrite_n <= wr ? 4'h0 : 4'hF;
      dataIn <= pipeWr[1] ? pipeData[1] : ~dataIn;
      pipeWr <= {pipeWr[0], wr};
      pipeData[1] <= pipeData[0];
      pipeData[0] <= d;
      @(posedge mclk);
      #1;
   endtask
endmodule

// ===== pipelined_sync_sram_port_test.sv
`timescale 1ns/100ps
module pipelined_sync_sram_port_test;
   import sram_port_pkg::*;
   logic mclk, rst_b, clockEnable_n, outputEnable_n, sleepRequest, burstOrderSelect;
   logic [ADDR_W-1:0] address;
   logic advanceOrLoad, writeSelect_n, chipSelectFirst_n, chipSelectSecond, chipSelectThird_n;
   logic [LANES-1:0] byteWrite_n;
   logic [DATA_W-1:0] dataIn, dataOut, held;
   logic [DATA_W-1:0] wdat [4];
   logic dataOe_n, captureReady, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdWord;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int error_cnt = 0;
   int samples_checked = 0;
   pipelined_sync_sram_port i_pipelined_sync_sram_port (.hready(hreadyout), .*);
   sram_controller_model i_sram_controller_model (.*);
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      rd = 32'h0;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge mclk);
            n++;
         end while (hreadyout !== 1'b1 && n < 20);
         if (hreadyout !== 1'b1) begin
            error_cnt++;
            finish_test;
         end
         if (p == 0) begin
            htrans <= 2'h0;
            hwdata <= wd;
         end else begin
            rd = hrdata;
         end
      end
      #1;
   endtask
   task automatic idle(input int n);
      repeat (n) i_sram_controller_model.cycle(1'b0, 1'b1, 3'h0, '0, '0);
   endtask
   task automatic readBurst(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e [4]);
      for (int k = 0; k < 7; k++) begin
         i_sram_controller_model.cycle(1'b0, k == 0 || k > 3, k < 4 ? 3'h7 : 3'h0, a, '0);
         if (k >= 2 && k < 6) cmp("dataOut", e[k-2], dataOut);
         if (k >= 3) cmp("dataOe_n", outputEnable_n, dataOe_n);
      end
   endtask
   task automatic regScenario;
      ahb(1'b0, 32'(CTRL_OFFSET), 32'h0, rdWord);
      cmp("ctrl", 32'h0, rdWord);
      ahb(1'b0, 32'hC, 32'h0, rdWord);
      cmp("unmapped", 32'h0, rdWord);
      ahb(1'b1, 32'(CTRL_OFFSET), 32'h1, rdWord);
      ahb(1'b0, 32'(CTRL_OFFSET), 32'h0, rdWord);
      cmp("ctrl", 32'h1, rdWord);
   endtask
   task automatic burstScenario;
      for (int k = 0; k < 4; k++) begin
         wdat[k] = 36'h9_8765_4320 + 36'(k);
         i_sram_controller_model.cycle(1'b1, k == 0, 3'h7, 22'h2, wdat[k]);
      end
      readBurst(22'h2, wdat);
      readBurst(22'h1, '{wdat[3], wdat[0], wdat[1], wdat[2]});
   endtask
   task automatic captureScenario;
      cmp("captureReady", 1'b0, captureReady);
      ahb(1'b0, 32'(STATUS_OFFSET), 32'h0, rdWord);
      cmp("status", 32'h2, rdWord);
      for (int k = 0; k < 9; k++) begin
         ahb(1'b0, 32'(CAPTURE_OFFSET), 32'h0, rdWord);
         cmp("capture", k < 4 ? wdat[k][31:0] : k < 8 ? wdat[(k + 3) % 4][31:0] : 32'h0, rdWord);
      end
      cmp("captureReady", 1'b1, captureReady);
      ahb(1'b1, 32'(CTRL_OFFSET), 32'h0, rdWord);
   endtask
   task automatic halfScenario;
      logic [DATA_W-1:0] lo, hi;
      lo = 36'h1_2345_6789;
      hi = 36'h5_4321_ABCD;
      ahb(1'b1, 32'(CTRL_OFFSET), 32'h2, rdWord);
      i_sram_controller_model.cycle(1'b1, 1'b1, 3'h7, 22'h8, lo);
      i_sram_controller_model.cycle(1'b1, 1'b1, 3'h7, 22'h9, hi);
      idle(2);
      i_sram_controller_model.cycle(1'b0, 1'b1, 3'h7, 22'h8, '0);
      i_sram_controller_model.cycle(1'b0, 1'b1, 3'h7, 22'h9, '0);
      idle(1);
      cmp("dataOut", {18'h00000, lo[17:0]}, dataOut);
      idle(1);
      cmp("dataOut", {18'h00000, hi[17:0]}, dataOut);
      ahb(1'b1, 32'(CTRL_OFFSET), 32'h0, rdWord);
   endtask
   task automatic resetScenario;
      rst_b <= 1'b0;
      burstOrderSelect <= 1'b1;
      idle(2);
      cmp("captureReady", 1'b0, captureReady);
      cmp("dataOe_n", 1'b1, dataOe_n);
      rst_b <= 1'b1;
      idle(1);
      cmp("captureReady", 1'b1, captureReady);
      idle(2);
      readBurst(22'h1, '{wdat[3], wdat[2], wdat[1], wdat[0]});
   endtask
   task automatic oeScenario;
      outputEnable_n <= 1'b1;
      idle(3);
      readBurst(22'h2, wdat);
      outputEnable_n <= 1'b0;
      idle(3);
   endtask
   task automatic freezeScenario;
      held = dataOut;
      clockEnable_n <= 1'b1;
      i_sram_controller_model.cycle(1'b0, 1'b1, 3'h7, 22'h1, '0);
      idle(3);
      cmp("dataOut", held, dataOut);
      cmp("dataOe_n", 1'b1, dataOe_n);
      clockEnable_n <= 1'b0;
      idle(1);
   endtask
   task automatic selectScenario;
      for (int m = 0; m < 7; m++) begin
         i_sram_controller_model.cycle(1'b0, 1'b1, 3'(m), 22'h2, '0);
         repeat (4) begin
            idle(1);
            cmp("dataOe_n", 1'b1, dataOe_n);
         end
      end
   endtask
   task automatic sleepScenario;
      sleepRequest <= 1'b1;
      idle(3);
      ahb(1'b0, 32'(STATUS_OFFSET), 32'h0, rdWord);
      cmp("status", 32'h9, rdWord);
      i_sram_controller_model.cycle(1'b0, 1'b1, 3'h7, 22'h2, '0);
      repeat (3) begin
         idle(1);
         cmp("dataOe_n", 1'b1, dataOe_n);
      end
      sleepRequest <= 1'b0;
      idle(2);
      readBurst(22'h2, wdat);
   endtask
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      repeat (5000) @(posedge mclk);
      error_cnt++;
      finish_test;
   end
   initial begin
      rst_b = 1'b0;
      clockEnable_n = 1'b0;
      outputEnable_n = 1'b0;
      sleepRequest = 1'b0;
      burstOrderSelect = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      #1;
      regScenario;
      burstScenario;
      captureScenario;
      halfScenario;
      resetScenario;
      oeScenario;
      freezeScenario;
      selectScenario;
      sleepScenario;
      finish_test;
   end
endmodule

bind pipelined_sync_sram_port sram_port_properties i_sram_port_properties (.*);
